//--- core/dftc_pkg.sv
package dftc_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] DFTC_OFF_OP_R1    = 8'h33;
  localparam logic [7:0] DFTC_OFF_OP_LOC   = 8'h34;
  localparam logic [7:0] DFTC_OFF_OP_R2    = 8'h35;
  localparam logic [7:0] DFTC_OFF_CTRL_ONE = 8'h36;
  localparam logic [7:0] DFTC_OFF_CTRL_TWO = 8'h37;
  localparam logic [7:0] DFTC_OFF_CONFIG   = 8'h40;
  localparam logic [7:0] DFTC_OFF_STATUS   = 8'h41;
  localparam logic [7:0] DFTC_OFF_FAN_START_TEMPERATURE_R1  = 8'h42;
  localparam logic [7:0] DFTC_OFF_FAN_START_TEMPERATURE_LOC = 8'h43;
  localparam logic [7:0] DFTC_OFF_FAN_START_TEMPERATURE_R2  = 8'h44;

  // values after reset
  localparam logic [7:0] DFTC_RST_OP       = 8'h64;
  localparam logic [7:0] DFTC_RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] DFTC_RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] DFTC_RST_CONFIG   = 8'h00;
  localparam logic [7:0] DFTC_RST_ZERO     = 8'h00;

  // bit positions in control register one
  localparam int DFTC_B_R2_CYC_MSB = 0;
  localparam int DFTC_B_VCCP_LOW   = 1;
  localparam int DFTC_B_CAP_R1     = 2;
  localparam int DFTC_B_CAP_LOC    = 3;
  localparam int DFTC_B_CAP_R2     = 4;
  localparam int DFTC_B_DYN_R1     = 5;
  localparam int DFTC_B_DYN_LOC    = 6;
  localparam int DFTC_B_DYN_R2     = 7;

  // field positions in control register two
  localparam int DFTC_F_R1_CYC_LO  = 0;
  localparam int DFTC_F_LOC_CYC_LO = 3;
  localparam int DFTC_F_R2_CYC_LO  = 6;

  // lock bit in the configuration register
  localparam int DFTC_B_LOCK = 1;

  // monitoring cycle timing: eight cycles make one second
  localparam int unsigned DFTC_MON_CYCLE_MS = 125;
  localparam int unsigned DFTC_CLK_MHZ      = 125;
  localparam int unsigned DFTC_MON_CYCLE_CLKS =
    DFTC_MON_CYCLE_MS * DFTC_CLK_MHZ * 1000;

  // base spacing in monitoring cycles for cycle code 000
  localparam logic [11:0] DFTC_DEC_BASE = 12'h008;
  localparam logic [11:0] DFTC_INC_BASE = 12'h010;
  localparam logic [11:0] DFTC_CNT_MAX  = 12'hfff;

  // per channel inputs from the conversion and fan logic
  typedef struct packed {
    logic [7:0] cur_temp;
    logic [7:0] fan_start_temperature_prog;
    logic [7:0] low_limit;
  } dftc_chan_in_s;

  // spacing in monitoring cycles for a cycle code and direction
  function automatic logic [11:0] dftc_wait(input logic [2:0] code,
                                            input logic       incr);
    logic [11:0] base;
    base = incr ? DFTC_INC_BASE : DFTC_DEC_BASE;
    return base << code;
  endfunction

endpackage

//--- core/dftc_chan.sv
`timescale 1ns/1ps
`default_nettype none

module dftc_chan
  import dftc_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          tick_i,
  input  wire logic          enable_i,
  input  wire logic [2:0]    cycle_code_i,
  input  wire dftc_chan_in_s chan_i,
  input  wire logic [7:0]    op_point_i,
  output logic      [7:0]    fan_start_temperature_o,
  output logic               adjust_o
);

  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic [7:0]  fan_start_temperature_reg;
  logic [7:0]  fan_start_temperature_next;
  logic        adj_reg;
  logic        adj_next;
  logic [11:0] cnt_inc;
  logic [11:0] dec_wait;
  logic [11:0] inc_wait;

  assign cnt_inc  = cnt_reg + 12'h001;
  assign dec_wait = dftc_wait(cycle_code_i, 1'b0);
  assign inc_wait = dftc_wait(cycle_code_i, 1'b1);

  // one step per allowed spacing; hot lowers the start point, cool raises it
  always_comb begin
    cnt_next  = cnt_reg;
    fan_start_temperature_next = fan_start_temperature_reg;
    adj_next  = 1'b0;
    if (!enable_i) begin
      cnt_next  = '0;
      fan_start_temperature_next = chan_i.fan_start_temperature_prog;
    end else if (tick_i) begin
      if (cnt_inc >= dec_wait && chan_i.cur_temp > op_point_i
          && fan_start_temperature_reg != 8'h00) begin
        fan_start_temperature_next = fan_start_temperature_reg - 8'h01;
        cnt_next  = '0;
        adj_next  = 1'b1;
      end else if (cnt_inc >= inc_wait
                   && chan_i.cur_temp < chan_i.low_limit
                   && fan_start_temperature_reg < op_point_i) begin
        fan_start_temperature_next = fan_start_temperature_reg + 8'h01;
        cnt_next  = '0;
        adj_next  = 1'b1;
      end else if (cnt_reg != DFTC_CNT_MAX) begin
        cnt_next = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg  <= '0;
      fan_start_temperature_reg <= DFTC_RST_ZERO;
      adj_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      fan_start_temperature_reg <= fan_start_temperature_next;
      adj_reg  <= adj_next;
    end
  end

  assign fan_start_temperature_o = fan_start_temperature_reg;
  assign adjust_o                = adj_reg;

endmodule

`default_nettype wire

//--- core/dftc_top.sv

`timescale 1ns/1ps
`default_nettype none

module dftc_top
  import dftc_pkg::*;
#(
  parameter int unsigned MON_CYCLE_CLKS = DFTC_MON_CYCLE_CLKS
)
(
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic [7:0]               addr_i,
  input  wire logic [7:0]               wr_data_i,
  input  wire logic                     wr_en_i,
  input  wire logic                     rd_en_i,
  output logic      [7:0]               rd_data_o,
  input  wire logic                     thermal_alarm_pin_n_i,
  input  wire dftc_chan_in_s [2:0]      chan_i,
  output logic      [2:0][7:0]          fan_start_temperature_o,
  output logic      [2:0]               adjust_o,
  output logic                          monitor_tick_o,
  output logic                          alarm_active_o,
  output logic                          lock_o
);

  //////////////////////////////////////////////////////////////////////////
  // channel index convention: 0 remote 1, 1 local, 2 remote 2

  localparam int NCH = 3;

  //////////////////////////////////////////////////////////////////////////
  // monitoring cycle divider

  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic        tick_reg;
  logic        tick_next;

  // one clock pulse per monitoring cycle; channels only step on it
  always_comb begin
    div_next  = div_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (div_reg >= 32'(MON_CYCLE_CLKS - 1)) begin
      div_next  = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg  <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign monitor_tick_o = tick_reg;

  //////////////////////////////////////////////////////////////////////////
  // thermal alarm pin synchroniser and assertion edge

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic sync1_next;
  logic sync2_next;
  logic prev_next;
  logic alarm_level;
  logic alarm_edge;

  // pin is active low and asynchronous; only sync2 and its delayed copy prev_reg feed logic
  always_comb begin
    sync1_next = thermal_alarm_pin_n_i;
    sync2_next = sync1_reg;
    prev_next  = sync2_reg;
  end

  // idle-high reset keeps a released pin from looking like an assertion
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  assign alarm_level    = ~sync2_reg;
  assign alarm_edge     = prev_reg & ~sync2_reg;
  assign alarm_active_o = alarm_level;

  //////////////////////////////////////////////////////////////////////////
  // software visible registers

  logic [NCH-1:0][7:0] op_reg;
  logic [NCH-1:0][7:0] op_next;
  logic [7:0]          ctrl_one_reg;
  logic [7:0]          ctrl_one_next;
  logic [7:0]          ctrl_two_reg;
  logic [7:0]          ctrl_two_next;
  logic [7:0]          config_reg;
  logic [7:0]          config_next;
  logic                locked;
  logic [NCH-1:0]      cap_en;
  logic [NCH-1:0]      dyn_en;
  logic [NCH-1:0][2:0] cyc_code;

  assign locked = config_reg[DFTC_B_LOCK];
  assign lock_o = locked;

  // capture enables per channel
  assign cap_en[0] = ctrl_one_reg[DFTC_B_CAP_R1];
  assign cap_en[1] = ctrl_one_reg[DFTC_B_CAP_LOC];
  assign cap_en[2] = ctrl_one_reg[DFTC_B_CAP_R2];

  // dynamic enables per channel
  assign dyn_en[0] = ctrl_one_reg[DFTC_B_DYN_R1];
  assign dyn_en[1] = ctrl_one_reg[DFTC_B_DYN_LOC];
  assign dyn_en[2] = ctrl_one_reg[DFTC_B_DYN_R2];

  // cycle codes; remote 2 code is split across both control registers
  assign cyc_code[0] = ctrl_two_reg[DFTC_F_R1_CYC_LO +: 3];
  assign cyc_code[1] = ctrl_two_reg[DFTC_F_LOC_CYC_LO +: 3];
  assign cyc_code[2] = {ctrl_one_reg[DFTC_B_R2_CYC_MSB],
                        ctrl_two_reg[DFTC_F_R2_CYC_LO +: 2]};

  // true when a write strobe targets the given offset
  function automatic logic wr_hit(input logic       en,
                                  input logic [7:0] addr,
                                  input logic [7:0] off);
    return en && (addr == off);
  endfunction

  // operating point offsets in channel order
  function automatic logic [7:0] op_off(input int ch);
    logic [7:0] off;
    off = DFTC_OFF_OP_R1;
    if (ch == 1) begin
      off = DFTC_OFF_OP_LOC;
    end else if (ch == 2) begin
      off = DFTC_OFF_OP_R2;
    end
    return off;
  endfunction

  // operating points: software writes unless locked, alarm capture wins
  always_comb begin
    op_next = op_reg;
    for (int ch = 0; ch < NCH; ch++) begin
      if (wr_hit(wr_en_i, addr_i, op_off(ch)) && !locked) begin
        op_next[ch] = wr_data_i;
      end
      // a disabled capture leaves the programmed value alone
      if (alarm_edge && cap_en[ch]) begin
        op_next[ch] = chan_i[ch].cur_temp;
      end
    end
  end

  // control register one freezes under lock; register two stays open
  always_comb begin
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    if (wr_hit(wr_en_i, addr_i, DFTC_OFF_CTRL_ONE) && !locked) begin
      ctrl_one_next = wr_data_i;
    end
    if (wr_hit(wr_en_i, addr_i, DFTC_OFF_CTRL_TWO)) begin
      ctrl_two_next = wr_data_i;
    end
  end

  // lock is sticky until reset so software cannot undo it
  always_comb begin
    config_next = config_reg;
    if (wr_hit(wr_en_i, addr_i, DFTC_OFF_CONFIG)) begin
      config_next[DFTC_B_LOCK] = locked | wr_data_i[DFTC_B_LOCK];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_reg       <= {NCH{DFTC_RST_OP}};
      ctrl_one_reg <= DFTC_RST_CTRL_ONE;
      ctrl_two_reg <= DFTC_RST_CTRL_TWO;
      config_reg   <= DFTC_RST_CONFIG;
    end else begin
      op_reg       <= op_next;
      ctrl_one_reg <= ctrl_one_next;
      ctrl_two_reg <= ctrl_two_next;
      config_reg   <= config_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per channel fan start temperature adjusters

  logic [NCH-1:0][7:0] fan_start_temperature_w;
  logic [NCH-1:0]      adj_w;

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    dftc_chan u_chan (
      .clk_i                   (clk_i),
      .nrst_i                  (nrst_i),
      .tick_i                  (tick_reg),
      .enable_i                (dyn_en[g]),
      .cycle_code_i            (cyc_code[g]),
      .chan_i                  (chan_i[g]),
      .op_point_i              (op_reg[g]),
      .fan_start_temperature_o (fan_start_temperature_w[g]),
      .adjust_o                (adj_w[g])
    );
  end

  assign fan_start_temperature_o = fan_start_temperature_w;
  assign adjust_o                = adj_w;

  //////////////////////////////////////////////////////////////////////////
  // status: alarm level, lock, channels moved off their programmed value

  logic [7:0] status;

  always_comb begin
    status    = 8'h00;
    status[0] = alarm_level;
    status[1] = locked;
    for (int ch = 0; ch < NCH; ch++) begin
      status[2 + ch] = dyn_en[ch] && (fan_start_temperature_w[ch] != chan_i[ch].fan_start_temperature_prog);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port: data appear in the cycle after the strobe, else zero

  logic [7:0] rd_reg;
  logic [7:0] rd_next;

  // unmapped offsets read zero so software sees no stale bus value
  always_comb begin
    rd_next = 8'h00;
    if (rd_en_i) begin
      if (addr_i == DFTC_OFF_OP_R1) begin
        rd_next = op_reg[0];
      end else if (addr_i == DFTC_OFF_OP_LOC) begin
        rd_next = op_reg[1];
      end else if (addr_i == DFTC_OFF_OP_R2) begin
        rd_next = op_reg[2];
      end else if (addr_i == DFTC_OFF_CTRL_ONE) begin
        rd_next = ctrl_one_reg;
      end else if (addr_i == DFTC_OFF_CTRL_TWO) begin
        rd_next = ctrl_two_reg;
      end else if (addr_i == DFTC_OFF_CONFIG) begin
        rd_next = config_reg;
      end else if (addr_i == DFTC_OFF_STATUS) begin
        rd_next = status;
      end else if (addr_i == DFTC_OFF_FAN_START_TEMPERATURE_R1) begin
        rd_next = fan_start_temperature_w[0];
      end else if (addr_i == DFTC_OFF_FAN_START_TEMPERATURE_LOC) begin
        rd_next = fan_start_temperature_w[1];
      end else if (addr_i == DFTC_OFF_FAN_START_TEMPERATURE_R2) begin
        rd_next = fan_start_temperature_w[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data_o = rd_reg;

endmodule

`default_nettype wire

//--- testbench/dftc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none

module dftc_top_checker
  import dftc_pkg::*;
#(
  parameter int unsigned MON_CYCLE_CLKS = 4
)
(
  input wire logic                clk_i,
  input wire logic                nrst_i,
  input wire logic [7:0]          addr_i,
  input wire logic [7:0]          wr_data_i,
  input wire logic                wr_en_i,
  input wire logic                rd_en_i,
  input wire logic [7:0]          rd_data_o,
  input wire logic                thermal_alarm_pin_n_i,
  input wire dftc_chan_in_s [2:0] chan_i,
  input wire logic [2:0][7:0]     fan_start_temperature_o,
  input wire logic [2:0]          adjust_o,
  input wire logic                monitor_tick_o,
  input wire logic                alarm_active_o,
  input wire logic                lock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last tick and the last remote 1 step
  logic [15:0] tgap_reg, tgap_next, agap_reg, agap_next;
  logic        tseen_reg, tseen_next, aseen_reg, aseen_next;

  always_comb begin
    tgap_next  = monitor_tick_o ? 16'h0000 : tgap_reg + 16'h0001;
    tseen_next = tseen_reg | monitor_tick_o;
    agap_next  = adjust_o[0] ? 16'h0000 : agap_reg + 16'h0001;
    aseen_next = aseen_reg | adjust_o[0];
  end

  // seen flags keep the first pulse after reset out of the gap checks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgap_reg  <= 16'h0000;
      tseen_reg <= 1'b0;
      agap_reg  <= 16'h0000;
      aseen_reg <= 1'b0;
    end else begin
      tgap_reg  <= tgap_next;
      tseen_reg <= tseen_next;
      agap_reg  <= agap_next;
      aseen_reg <= aseen_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence pin_low_run;
    !thermal_alarm_pin_n_i [*4];
  endsequence
  sequence pin_high_run;
    thermal_alarm_pin_n_i [*4];
  endsequence
  sequence lock_write;
    wr_en_i && addr_i == DFTC_OFF_CONFIG && wr_data_i[DFTC_B_LOCK];
  endsequence

  a_read_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
    else $error("read data not zero outside read slot");
  a_unmapped_read: assert property (rd_en_i && addr_i < DFTC_OFF_OP_R1
    |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
  a_tick_spacing: assert property (monitor_tick_o && tseen_reg
    |-> tgap_reg == 16'(MON_CYCLE_CLKS - 1)) else $error("tick spacing");
  a_alarm_sync: assert property (pin_low_run |-> alarm_active_o)
    else $error("alarm not seen");
  a_alarm_release: assert property (pin_high_run |-> !alarm_active_o)
    else $error("alarm stuck");
  a_lock_set: assert property (lock_write |=> lock_o)
    else $error("lock not set");
  a_lock_sticky: assert property (lock_o |=> lock_o)
    else $error("lock released");
  a_adjust_pulse: assert property (adjust_o[0] |=> !adjust_o[0])
    else $error("step pulse too long");
  a_adjust_gap: assert property (adjust_o[0] && aseen_reg
    |-> agap_reg >= 16'(8 * MON_CYCLE_CLKS - 1)) else $error("steps too close");
endmodule

`default_nettype wire

//--- testbench/dynamic_fan_threshold_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module dynamic_fan_threshold_control_tb_top
  import dftc_pkg::*;
;
  localparam int unsigned MON = 4;
  logic                clk, nrst, wr, rd, pin_n, tick, alarm, lock;
  logic [7:0]          addr, wdata, rdata, p [3], t [3];
  dftc_chan_in_s [2:0] chan;
  logic [2:0][7:0]     fst;
  logic [2:0]          adj;
  int                  err_count, comparisons, n;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  dftc_top #(.MON_CYCLE_CLKS(MON)) i_dut (.clk_i(clk), .nrst_i(nrst),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr), .rd_en_i(rd),
    .rd_data_o(rdata), .thermal_alarm_pin_n_i(pin_n), .chan_i(chan),
    .fan_start_temperature_o(fst), .adjust_o(adj), .monitor_tick_o(tick),
    .alarm_active_o(alarm), .lock_o(lock));

  ////////////////////////////////////////////////////////////////////////////
  // verdict in one place for the main sequence and the watchdog
  task automatic complete_run();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    comparisons++;
    if (g != e) begin
      err_count++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask

  // strobes drop for one edge so back to back calls never clash
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk8("rd_data_o", e, rdata);
    @(posedge clk);
  endtask

  // counts negedges up to the next step pulse, then one cycle more
  task automatic wait_adj(input int ch, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (adj[ch] !== 1'b1 && cnt < 20000);
    @(negedge clk);
  endtask

  // gap between two steps on one channel and the step direction
  task automatic dyn(input int ch, input logic [7:0] c1, c2, cur, low, fan_start_temperature,
                     input int span, input bit up);
    logic [7:0] f1;
    wr_reg(DFTC_OFF_CTRL_ONE, 8'h00);
    for (int i = 0; i < 3; i++) begin
      chan[i] <= '{cur, fan_start_temperature, low};
      wr_reg(DFTC_OFF_OP_R1 + 8'(i), 8'h30);
    end
    wr_reg(DFTC_OFF_CTRL_TWO, c2);
    wr_reg(DFTC_OFF_CTRL_ONE, c1);
    wait_adj(ch, n);
    f1 = fst[ch];
    wait_adj(ch, n);
    chk_n("step gap", span * MON - 1, n);
    chk8("fan_start", up ? f1 + 8'h01 : f1 - 8'h01, fst[ch]);
    for (int i = 0; i < 3; i++) begin
      if (!c1[5 + i]) chk8("fan_start", fan_start_temperature, fst[i]);
    end
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'he15d78c0));
    {nrst, wr, rd, addr, wdata} = '0;
    pin_n = 1'b1;
    chan  = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset values, unmapped place, then random write and read back
    for (int i = 0; i < 3; i++) rd_chk(DFTC_OFF_OP_R1 + 8'(i), DFTC_RST_OP);
    rd_chk(DFTC_OFF_CTRL_ONE, DFTC_RST_CTRL_ONE);
    rd_chk(DFTC_OFF_CTRL_TWO, DFTC_RST_CTRL_TWO);
    wr_reg(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
    for (int i = 0; i < 5; i++) begin
      p[0] = 8'($urandom);
      wr_reg(DFTC_OFF_OP_R1 + 8'(i), p[0]);
      rd_chk(DFTC_OFF_OP_R1 + 8'(i), p[0]);
    end
    wr_reg(DFTC_OFF_CTRL_TWO, 8'h00);
    // every capture mask against one alarm assertion
    for (int m = 0; m < 8; m++) begin
      for (int i = 0; i < 3; i++) begin
        p[i] = 8'($urandom);
        t[i] = 8'($urandom);
        chan[i] <= '{t[i], 8'h40, 8'h20};
        wr_reg(DFTC_OFF_OP_R1 + 8'(i), p[i]);
      end
      wr_reg(DFTC_OFF_CTRL_ONE, 8'(m << 2));
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 3; i++) rd_chk(DFTC_OFF_OP_R1 + 8'(i), m[i] ? t[i] : p[i]);
    end
    // dynamic steps, both directions and several cycle codes
    dyn(0, 8'h20, 8'h00, 8'h50, 8'h20, 8'h40, 8, 0);
    dyn(0, 8'h20, 8'h01, 8'h50, 8'h20, 8'h40, 16, 0);
    dyn(0, 8'h20, 8'h00, 8'h10, 8'h20, 8'h20, 16, 1);
    dyn(1, 8'h40, 8'h08, 8'h50, 8'h20, 8'h40, 16, 0);
    dyn(2, 8'h81, 8'h40, 8'h50, 8'h20, 8'h40, 256, 0);
    // lock freezes operating points and control one, not control two
    wr_reg(DFTC_OFF_OP_R1, 8'h55);
    wr_reg(DFTC_OFF_CTRL_ONE, 8'h00);
    wr_reg(DFTC_OFF_CONFIG, 8'h02);
    wr_reg(DFTC_OFF_OP_R1, 8'haa);
    wr_reg(DFTC_OFF_CTRL_ONE, 8'hff);
    wr_reg(DFTC_OFF_CTRL_TWO, 8'h12);
    chk8("lock_o", 8'h01, {7'h00, lock});
    rd_chk(DFTC_OFF_OP_R1, 8'h55);
    rd_chk(DFTC_OFF_CTRL_ONE, 8'h00);
    rd_chk(DFTC_OFF_CTRL_TWO, 8'h12);
    // lock bit readable, status shows lock only, start points back on program
    rd_chk(DFTC_OFF_CONFIG, 8'h02);
    rd_chk(DFTC_OFF_STATUS, 8'h02);
    for (int i = 0; i < 3; i++) rd_chk(DFTC_OFF_FAN_START_TEMPERATURE_R1 + 8'(i), 8'h40);
    complete_run();
  end
endmodule

bind dftc_top dftc_top_checker #(.MON_CYCLE_CLKS(MON_CYCLE_CLKS)) i_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
  .thermal_alarm_pin_n_i(thermal_alarm_pin_n_i), .chan_i(chan_i),
  .fan_start_temperature_o(fan_start_temperature_o), .adjust_o(adjust_o),
  .monitor_tick_o(monitor_tick_o), .alarm_active_o(alarm_active_o),
  .lock_o(lock_o));

`default_nettype wire
